// >>> hdl/cju_pkg.sv
package cju_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ****************************************************************
  // opcodes of the relative jump group
  // ****************************************************************
  localparam logic [7:0] OP_JUMP_ALWAYS = 8'h20;
  localparam logic [7:0] OP_JUMP_NEVER = 8'h21;
  localparam logic [7:0] OP_JUMP_UNSIGNED_ABOVE = 8'h22;
  localparam logic [7:0] OP_JUMP_UNSIGNED_AT_MOST = 8'h23;
  localparam logic [7:0] OP_JUMP_CARRY_CLEAR = 8'h24;
  localparam logic [7:0] OP_JUMP_CARRY_SET = 8'h25;
  localparam logic [7:0] OP_JUMP_ON_UNEQUAL = 8'h26;
  localparam logic [7:0] OP_JUMP_ON_EQUAL = 8'h27;
  localparam logic [7:0] OP_JUMP_OVERFLOW_CLEAR = 8'h28;
  localparam logic [7:0] OP_JUMP_OVERFLOW_SET = 8'h29;
  localparam logic [7:0] OP_JUMP_ON_POSITIVE = 8'h2a;
  localparam logic [7:0] OP_JUMP_ON_NEGATIVE = 8'h2b;
  localparam logic [7:0] OP_JUMP_SIGNED_AT_LEAST = 8'h2c;
  localparam logic [7:0] OP_JUMP_SIGNED_BELOW = 8'h2d;
  localparam logic [7:0] OP_JUMP_SIGNED_ABOVE = 8'h2e;
  localparam logic [7:0] OP_JUMP_SIGNED_AT_MOST = 8'h2f;
  localparam logic [3:0] OP_GROUP_HI = 4'h2;

  // ****************************************************************
  // addresses, lengths and reset values
  // ****************************************************************
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  localparam logic [15:0] INSTR_LEN = 16'h0002;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ****************************************************************
  // flag bit positions in condition_flag_register
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    CJU_FETCH_OP,
    CJU_FETCH_DISP,
    CJU_DUMMY
  } cju_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd_wr_n;
  } cju_bus_t;

endpackage

// >>> hdl/cju_cond_eval.sv
`timescale 1ns/1ps
// ****************************************************************
// condition evaluation for the jump opcodes
// ****************************************************************
module cju_cond_eval (
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] flags_i,
  output logic take_o,
  output logic is_jump_o
);
  logic flag_c;
  logic flag_v;
  logic flag_z;
  logic flag_n;
  logic nxv;
  logic czo;
  logic base_cond;

  assign flag_c = flags_i[cju_pkg::FLAG_C];
  assign flag_v = flags_i[cju_pkg::FLAG_V];
  assign flag_z = flags_i[cju_pkg::FLAG_Z];
  assign flag_n = flags_i[cju_pkg::FLAG_N];
  assign nxv = flag_n ^ flag_v;
  assign czo = flag_c | flag_z;
  assign is_jump_o = (opcode_i[7:4] == cju_pkg::OP_GROUP_HI);

  // odd opcodes jump when their test holds, even ones on its inverse
  always_comb begin
    base_cond = 1'b0;
    unique case (opcode_i)
      cju_pkg::OP_JUMP_ALWAYS: base_cond = 1'b1;
      cju_pkg::OP_JUMP_NEVER: base_cond = 1'b0;
      cju_pkg::OP_JUMP_UNSIGNED_ABOVE: base_cond = ~czo;
      cju_pkg::OP_JUMP_UNSIGNED_AT_MOST: base_cond = czo;
      cju_pkg::OP_JUMP_CARRY_CLEAR: base_cond = ~flag_c;
      cju_pkg::OP_JUMP_CARRY_SET: base_cond = flag_c;
      cju_pkg::OP_JUMP_ON_UNEQUAL: base_cond = ~flag_z;
      cju_pkg::OP_JUMP_ON_EQUAL: base_cond = flag_z;
      cju_pkg::OP_JUMP_OVERFLOW_CLEAR: base_cond = ~flag_v;
      cju_pkg::OP_JUMP_OVERFLOW_SET: base_cond = flag_v;
      cju_pkg::OP_JUMP_ON_POSITIVE: base_cond = ~flag_n;
      cju_pkg::OP_JUMP_ON_NEGATIVE: base_cond = flag_n;
      cju_pkg::OP_JUMP_SIGNED_AT_LEAST: base_cond = ~nxv;
      cju_pkg::OP_JUMP_SIGNED_BELOW: base_cond = nxv;
      cju_pkg::OP_JUMP_SIGNED_ABOVE: base_cond = ~(flag_z | nxv);
      cju_pkg::OP_JUMP_SIGNED_AT_MOST: base_cond = flag_z | nxv;
      default: base_cond = 1'b0; // opcodes outside the group never jump
    endcase
  end

  assign take_o = base_cond;
endmodule

// >>> hdl/cju_target_calc.sv
`timescale 1ns/1ps
// ****************************************************************
// next program counter from opcode address and displacement
// ****************************************************************
module cju_target_calc (
  input wire logic [15:0] op_addr_i,
  input wire logic [7:0] disp_i,
  input wire logic take_i,
  output logic [15:0] next_pc_o
);
  logic [15:0] fall_pc;
  logic [15:0] disp_ext;

  // twos-complement sign extension keeps backward jumps reachable
  assign disp_ext = {{8{disp_i[7]}}, disp_i};
  assign fall_pc = op_addr_i + cju_pkg::INSTR_LEN;
  // wraps modulo 64k, as the address bus does
  assign next_pc_o = take_i ? 16'(fall_pc + disp_ext) : fall_pc;
endmodule

// >>> hdl/cju_top.sv
`timescale 1ns/1ps
// Functional notes
// - opcode 27 jumps when zero set
// - opcode 2C jumps when N xor V clear
// - opcode 2E jumps when Z or (N^V) clear
// - taken target is opcode address+2+displacement
// - three reads: opcode, displacement, dummy FFFF
// - jumps never alter the flag register
// - 2F, 2D, 26 complementary signed/equal jumps
// - 22, 23, 24, 25 unsigned jumps
// - 2B/2A negative, 29/28 overflow, 20/21 unconditional
// - two bytes: opcode plus displacement, relative
module cju_top (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [15:0] start_pc_i,
  input wire logic [7:0] flags_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_wr_n_o,
  output logic busy_o,
  output logic done_o,
  output logic taken_o,
  output logic illegal_o,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o
);

  // ****************************************************************
  // state and registers
  // ****************************************************************
  cju_pkg::cju_state_t state_r;
  cju_pkg::cju_state_t state_nxt;
  logic active_r;
  logic [15:0] op_addr_r;
  logic [7:0] opcode_r;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0] flags_r;
  logic done_r;
  logic taken_r;
  logic illegal_r;
  cju_pkg::cju_bus_t bus_r;
  cju_pkg::cju_bus_t bus_nxt;

  // ****************************************************************
  // decode and target
  // ****************************************************************
  logic cond_take;
  logic op_is_jump;
  logic [15:0] target_pc;
  logic in_op;
  logic in_disp;
  logic in_dummy;

  assign in_op = active_r && (state_r == cju_pkg::CJU_FETCH_OP);
  assign in_disp = active_r && (state_r == cju_pkg::CJU_FETCH_DISP);
  assign in_dummy = active_r && (state_r == cju_pkg::CJU_DUMMY);

  // flags sampled once into the hold register so the test is stable
  cju_cond_eval u_cond (
    .opcode_i(opcode_r),
    .flags_i(flags_r),
    .take_o(cond_take),
    .is_jump_o(op_is_jump)
  );

  // displacement arrives in cycle two and is used straight off the bus
  cju_target_calc u_target (
    .op_addr_i(op_addr_r),
    .disp_i(mem_rdata_i),
    .take_i(cond_take & op_is_jump),
    .next_pc_o(target_pc)
  );

  // ****************************************************************
  // sequencing of the three bus cycles
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    bus_nxt = bus_r;
    pc_nxt = pc_r;
    unique case (state_r)
      cju_pkg::CJU_FETCH_OP: begin
        if (in_op) begin
          state_nxt = cju_pkg::CJU_FETCH_DISP;
          bus_nxt.addr = 16'(op_addr_r + 16'h0001);
        end
      end
      cju_pkg::CJU_FETCH_DISP: begin
        state_nxt = cju_pkg::CJU_DUMMY;
        bus_nxt.addr = cju_pkg::DUMMY_ADDR;
        pc_nxt = target_pc;
      end
      cju_pkg::CJU_DUMMY: begin
        state_nxt = cju_pkg::CJU_FETCH_OP;
        bus_nxt.addr = pc_r;
      end
    endcase
    bus_nxt.rd_wr_n = 1'b1;
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= cju_pkg::CJU_FETCH_OP;
      active_r <= 1'b0;
    end else if (!active_r) begin
      state_r <= cju_pkg::CJU_FETCH_OP;
      active_r <= start_i;
    end else begin
      state_r <= state_nxt;
      active_r <= !in_dummy;
    end
  end

  // captures at instruction start
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      op_addr_r <= cju_pkg::PC_RST;
      flags_r <= cju_pkg::FLAGS_RST;
    end else if (!active_r && start_i) begin
      op_addr_r <= start_pc_i;
      flags_r <= flags_i;
    end
  end

  // opcode taken in cycle one; flags_r is never written mid-jump
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      opcode_r <= 8'h00;
    end else if (in_op) begin
      opcode_r <= mem_rdata_i;
    end
  end

  // program counter: loaded at start, updated after the displacement
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pc_r <= cju_pkg::PC_RST;
    end else if (!active_r && start_i) begin
      pc_r <= start_pc_i;
    end else if (in_disp) begin
      pc_r <= pc_nxt;
    end
  end

  // bus outputs registered; idle drives the start address ahead of time
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_r.addr <= cju_pkg::PC_RST;
      bus_r.rd_wr_n <= 1'b1;
    end else if (!active_r) begin
      bus_r.addr <= start_i ? start_pc_i : bus_r.addr;
      bus_r.rd_wr_n <= 1'b1;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // completion pulse the cycle after the dummy cycle; outcome flags shown with the dummy cycle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      done_r <= 1'b0;
      taken_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      done_r <= in_dummy;
      if (in_disp) begin
        taken_r <= cond_take & op_is_jump;
        illegal_r <= ~op_is_jump;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mem_addr_o = bus_r.addr;
  assign mem_rd_wr_n_o = bus_r.rd_wr_n;
  assign busy_o = active_r;
  assign done_o = done_r;
  assign taken_o = taken_r;
  assign illegal_o = illegal_r;
  assign pc_o = pc_r;
  assign flags_o = flags_r;
endmodule

// >>> dv/cju_ref_pkg.sv
package cju_ref_pkg;
  // expected jump decision; odd opcodes take on the flag test, even on its inverse
  function automatic logic want_take(input logic [7:0] op, input logic [7:0] f);
    logic t;
    case (op[3:1])
      3'h0: t = 1'b0;
      3'h1: t = f[0] | f[2];
      3'h2: t = f[0];
      3'h3: t = f[2];
      3'h4: t = f[1];
      3'h5: t = f[3];
      3'h6: t = f[3] ^ f[1];
      default: t = f[2] | (f[3] ^ f[1]);
    endcase
    return (op[7:4] == 4'h2) && (t == op[0]);
  endfunction
endpackage

// >>> dv/cju_prog_mem.sv
`timescale 1ns/1ps
// ****************************************************************
// program memory model
// ****************************************************************
module cju_prog_mem (
  input wire logic [15:0] addr_i,
  input wire logic rd_wr_n_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [logic [15:0]];
  // unloaded places answer a pattern so a stale byte never passes
  function automatic logic [7:0] look();
    return (rd_wr_n_i && mem.exists(addr_i)) ? mem[addr_i] : ~addr_i[7:0];
  endfunction
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
    rdata_o = look();
  endtask
  // answer in the same cycle as the address
  always @(addr_i or rd_wr_n_i) begin
    rdata_o = look();
  end
endmodule

// >>> dv/cju_checker.sv
`timescale 1ns/1ps
module cju_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [15:0] start_pc_i,
  input wire logic [7:0] flags_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_wr_n_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic taken_o,
  input wire logic illegal_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] flags_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [1:0] ph_r;
  logic [15:0] pc_r;
  logic [7:0] flg_r;
  logic [7:0] op_r;
  logic [7:0] disp_r;
  wire go = start_i && !busy_o;
  wire want = cju_ref_pkg::want_take(op_r, flg_r);
  // capture each instruction as it passes the bus
  always_ff @(posedge clock_i) begin
    ph_r <= sys_rst_i ? 2'h0 : ((ph_r != 2'h0) ? ph_r + 2'h1 : {1'b0, go});
    pc_r <= go ? start_pc_i : pc_r;
    flg_r <= go ? flags_i : flg_r;
    op_r <= (ph_r == 2'h1) ? mem_rdata_i : op_r;
    disp_r <= (ph_r == 2'h2) ? mem_rdata_i : disp_r;
  end
  property p_bus_seq;
    go |=> mem_addr_o == pc_r ##1 mem_addr_o == pc_r + 16'h0001 ##1 mem_addr_o == 16'hffff;
  endproperty
  a_bus_seq: assert property (p_bus_seq)
    else $error("bus sequence wrong");
  property p_busy;
    go |=> busy_o [*3] ##1 (!busy_o && done_o);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy span wrong");
  property p_rd;
    mem_rd_wr_n_o;
  endproperty
  a_rd: assert property (p_rd)
    else $error("write seen");
  property p_done_pulse;
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done too long");
  property p_flags;
    done_o |-> flags_o == flg_r;
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags changed");
  property p_pc;
    done_o |-> pc_o == pc_r + 16'h0002 + (want ? {{8{disp_r[7]}}, disp_r} : 16'h0000);
  endproperty
  a_pc: assert property (p_pc)
    else $error("next pc wrong");
  property p_take;
    done_o |-> taken_o == want;
  endproperty
  a_take: assert property (p_take)
    else $error("jump decision wrong");
  property p_illegal;
    done_o |-> illegal_o == (op_r[7:4] != 4'h2);
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal flag wrong");
  c_taken: cover property (done_o && taken_o);
  c_fall: cover property (done_o && !taken_o);
  c_illegal: cover property (done_o && illegal_o);
endmodule
bind cju_top cju_checker chk_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
  .start_pc_i(start_pc_i), .flags_i(flags_i), .mem_rdata_i(mem_rdata_i),
  .mem_addr_o(mem_addr_o), .mem_rd_wr_n_o(mem_rd_wr_n_o), .busy_o(busy_o), .done_o(done_o),
  .taken_o(taken_o), .illegal_o(illegal_o), .pc_o(pc_o), .flags_o(flags_o));

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [15:0] start_pc_i = 16'h0000;
  logic [7:0] flags_i = 8'h00;
  wire logic [7:0] mem_rdata_i;
  logic [15:0] mem_addr_o;
  logic [15:0] pc_o;
  logic [7:0] flags_o;
  logic mem_rd_wr_n_o, busy_o, done_o, taken_o, illegal_o;
  int num_errors = 0;
  int checks = 0;
  always #5 clock_i = ~clock_i;
  cju_top dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .start_pc_i(start_pc_i), .flags_i(flags_i), .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o), .mem_rd_wr_n_o(mem_rd_wr_n_o), .busy_o(busy_o), .done_o(done_o),
    .taken_o(taken_o), .illegal_o(illegal_o), .pc_o(pc_o), .flags_o(flags_o));
  cju_prog_mem mem_u (.addr_i(mem_addr_o), .rd_wr_n_i(mem_rd_wr_n_o), .rdata_o(mem_rdata_i));
  // ****************************************************************
  // compare and drive helpers
  // ****************************************************************
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // every output but mem_rd_wr_n_o at its reset value
  task automatic chk_rst;
    chk_word(pc_o, cju_pkg::PC_RST);
    chk_word(mem_addr_o, cju_pkg::PC_RST);
    chk_word({8'h00, flags_o}, {8'h00, cju_pkg::FLAGS_RST});
    chk_bit(busy_o, 1'b0);
    chk_bit(done_o, 1'b0);
    chk_bit(taken_o, 1'b0);
    chk_bit(illegal_o, 1'b0);
  endtask
  // called on the start edge; walks the three reads, then counts edges to done
  task automatic wait_done(input logic [15:0] a);
    int n;
    n = 0;
    #1;
    chk_word(mem_addr_o, a);
    chk_bit(busy_o, 1'b1);
    do begin
      @(posedge clock_i);
      #1;
      n++;
      chk_bit(mem_rd_wr_n_o, 1'b1);
      if (n == 1) chk_word(mem_addr_o, 16'(a + 16'h0001));
      if (n == 2) chk_word(mem_addr_o, cju_pkg::DUMMY_ADDR);
    end while (done_o !== 1'b1 && n < 8);
    chk_word(16'(n), 16'h0003);
  endtask
  task automatic check_res(input logic [15:0] a, input logic [7:0] op, d, f);
    logic t;
    logic [15:0] npc;
    t = cju_ref_pkg::want_take(op, f);
    npc = a + 16'h0002 + (t ? {{8{d[7]}}, d} : 16'h0000);
    chk_bit(taken_o, t);
    chk_word(pc_o, npc);
    chk_word(mem_addr_o, npc);
    chk_word({8'h00, flags_o}, {8'h00, f});
    chk_bit(illegal_o, op[7:4] != 4'h2);
  endtask
  task automatic one_jump(input logic [15:0] a, input logic [7:0] op, d, f);
    mem_u.put(a, op);
    mem_u.put(a + 16'h0001, d);
    @(posedge clock_i);
    start_i <= 1'b1;
    start_pc_i <= a;
    flags_i <= f;
    @(posedge clock_i);
    start_i <= 1'b0;
    wait_done(a);
    check_res(a, op, d, f);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_opcodes;
    logic [15:0] a;
    logic [7:0] op;
    logic [3:0] fl;
    for (int o = 0; o < 16; o++) begin
      for (int f = 0; f < 16; f++) begin
        op = cju_pkg::OP_JUMP_ALWAYS | 8'(o);
        fl = 4'(f);
        a = {4'h1, op[3:0], fl, 4'h0};
        one_jump(a, op, {fl, op[3:0]}, {fl, fl});
      end
    end
    $display("test opcodes done");
  endtask
  // address arithmetic wraps at both ends of the 64k space
  task automatic test_wrap;
    one_jump(16'hfffe, cju_pkg::OP_JUMP_ALWAYS, 8'h7f, 8'h00);
    one_jump(16'h0000, cju_pkg::OP_JUMP_ALWAYS, 8'h80, 8'h00);
    $display("test wrap done");
  endtask
  task automatic test_illegal;
    one_jump(16'h0300, 8'h12, 8'h40, 8'h0f);
    one_jump(16'h0310, 8'h3f, 8'h40, 8'h00);
    $display("test illegal done");
  endtask
  // start held high: the second request is not taken while busy, and starts its jump once the first is done
  task automatic test_back2back;
    mem_u.put(16'h0400, cju_pkg::OP_JUMP_ON_EQUAL);
    mem_u.put(16'h0401, 8'h10);
    mem_u.put(16'h0500, cju_pkg::OP_JUMP_ON_UNEQUAL);
    mem_u.put(16'h0501, 8'hf0);
    @(posedge clock_i);
    start_i <= 1'b1;
    start_pc_i <= 16'h0400;
    flags_i <= 8'h04;
    @(posedge clock_i);
    start_pc_i <= 16'h0500;
    flags_i <= 8'h00;
    wait_done(16'h0400);
    check_res(16'h0400, 8'h27, 8'h10, 8'h04);
    @(posedge clock_i);
    start_i <= 1'b0;
    wait_done(16'h0500);
    check_res(16'h0500, 8'h26, 8'hf0, 8'h00);
    $display("test back to back done");
  endtask
  // reset in mid-jump drops the sequence and clears every output but mem_rd_wr_n_o, which stays high
  task automatic test_reset;
    mem_u.put(16'h0600, cju_pkg::OP_JUMP_ALWAYS);
    mem_u.put(16'h0601, 8'h20);
    @(posedge clock_i);
    start_i <= 1'b1;
    start_pc_i <= 16'h0600;
    flags_i <= 8'h0f;
    @(posedge clock_i);
    start_i <= 1'b0;
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk_rst();
    one_jump(16'h0600, cju_pkg::OP_JUMP_ALWAYS, 8'h20, 8'h0f);
    $display("test reset done");
  endtask
  task automatic final_report;
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 1320 cycles expected; cut a hang well beyond that
  initial begin
    #40000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk_rst();
    test_opcodes();
    test_wrap();
    test_illegal();
    test_back2back();
    test_reset();
    final_report();
  end
endmodule
